//--- hw/abe_enable_regs.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// - High-side bypass bit set skips the high-side dead-time delay
// - Bit 4 set bypasses low-side delay; clear keeps low-side dead time
// - Bypass clear adds dead-time register value to matching turn-on edge
// - Bit 3 drives weak pull-down on negative sense input
// - Bit 2 drives weak pull-up on positive sense input
// - Bit 1 enables the output undervoltage accelerator
// - Enabled undervoltage accelerator forces both gate drives low on the third clock after the fault pin rises
// - Bit 0 enables the output overvoltage accelerator
// - Enabled overvoltage accelerator forces both gate drives low on the third clock after the fault pin rises
// - Overvoltage detect enable activates detection; clear ignores its threshold
// - Undervoltage detect enable activates detection; clear ignores its threshold
// - Writing 1 to measurement-start bit starts an efficiency measurement
// - Slope-compensation bypass bit bypasses slope compensation
// - Current measurement enable bit powers peak current measurement
// - Temperature sensor powered only while its enable bit is set
// - Efficiency-circuit enable powers efficiency circuitry, separate from start
// - Signal-path enable bit enables the voltage control path
module abe_enable_regs #(
    parameter int DEAD_W = abe_pkg::ABE_DEAD_W
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write address
    input wire logic [abe_pkg::ABE_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [abe_pkg::ABE_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog fault pins and raw PWM
    input wire logic ov_fault_pin,
    input wire logic uv_fault_pin,
    input wire logic pwm_high,
    input wire logic pwm_low,
    // Analog enables
    output logic neg_sense_pulldown_en,
    output logic pos_sense_pullup_en,
    output logic overvoltage_detect_en,
    output logic undervoltage_detect_en,
    output logic efficiency_meas_start,
    output logic slope_comp_bypass,
    output logic current_meas_en,
    output logic temp_sensor_en,
    output logic efficiency_circuit_en,
    output logic voltage_path_en,
    // Gate drives
    output logic high_side_gate_drive,
    output logic low_side_gate_drive
);
    import abe_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [ABE_REG_W-1:0] periph_q;
    logic [ABE_REG_W-1:0] analog_q;
    logic [DEAD_W-1:0] dead_q;
    logic [ABE_ADDR_W-1:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    logic meas_start_q;
    logic [1:0] ov_sync_q;
    logic [1:0] uv_sync_q;
    logic [1:0] ph_sync_q;
    logic [1:0] pl_sync_q;
    logic ph_prev_q;
    logic pl_prev_q;
    logic [DEAD_W-1:0] hcnt_q;
    logic [DEAD_W-1:0] lcnt_q;
    logic high_side_gate_drive_q;
    logic low_side_gate_drive_q;

    logic do_write;
    logic ov_trip;
    logic uv_trip;
    logic kill;
    logic high_side_gate_drive_d;
    logic low_side_gate_drive_d;

    ////////////////////////////////////////////////////////////////////////
    // Write channels accepted in either order, response after both
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
            s_axi_awready <= 1'b0;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_wready <= 1'b0;
        end
        else if (clk_en)
        begin
            s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ABE_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == ABE_PERIPH_EN_ADDR ||
                    awaddr_q == ABE_ANALOG_EN_ADDR || awaddr_q == ABE_DEAD_TIME_ADDR)
                    ? ABE_RESP_OKAY : ABE_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage; only byte lane 0 carries data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            periph_q <= ABE_PE_RESET;
            analog_q <= ABE_AE_RESET;
            dead_q <= DEAD_W'(ABE_DEAD_RESET);
        end
        else if (clk_en && do_write && wstrb_q[0])
        begin
            unique case (awaddr_q)
                ABE_PERIPH_EN_ADDR: periph_q <= wdata_q[ABE_REG_W-1:0];
                ABE_ANALOG_EN_ADDR: analog_q <= wdata_q[ABE_REG_W-1:0];
                ABE_DEAD_TIME_ADDR: dead_q <= wdata_q[DEAD_W-1:0];
                default: ;
            endcase
        end
    end

    // Start pulse fires on each write of 1, not on the stored level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            meas_start_q <= 1'b0;
        else if (clk_en)
            meas_start_q <= do_write && wstrb_q[0] && awaddr_q == ABE_ANALOG_EN_ADDR
                && wdata_q[ABE_AE_MEAS_START];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= ABE_RESP_OKAY;
        end
        else if (clk_en)
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= ABE_RESP_OKAY;
                unique case (s_axi_araddr)
                    ABE_PERIPH_EN_ADDR: s_axi_rdata <= 32'(periph_q);
                    ABE_ANALOG_EN_ADDR: s_axi_rdata <= 32'(analog_q);
                    ABE_DEAD_TIME_ADDR: s_axi_rdata <= 32'(dead_q);
                    ABE_STATUS_ADDR: s_axi_rdata <= 32'({high_side_gate_drive_q, low_side_gate_drive_q, uv_trip, ov_trip}
                        & 4'hf) << 0;
                    default:
                    begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= ABE_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ov_sync_q <= '0;
            uv_sync_q <= '0;
            ph_sync_q <= '0;
            pl_sync_q <= '0;
            ph_prev_q <= 1'b0;
            pl_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ov_sync_q <= {ov_sync_q[0], ov_fault_pin};
            uv_sync_q <= {uv_sync_q[0], uv_fault_pin};
            ph_sync_q <= {ph_sync_q[0], pwm_high};
            pl_sync_q <= {pl_sync_q[0], pwm_low};
            ph_prev_q <= ph_sync_q[1];
            pl_prev_q <= pl_sync_q[1];
        end
    end

    // A fault only counts when its comparator is powered
    assign ov_trip = ov_sync_q[1] && analog_q[ABE_AE_OV_DET];
    assign uv_trip = uv_sync_q[1] && analog_q[ABE_AE_UV_DET];
    assign kill = (ov_trip && periph_q[ABE_PE_OV_ACCEL]) ||
        (uv_trip && periph_q[ABE_PE_UV_ACCEL]);

    ////////////////////////////////////////////////////////////////////////
    // Dead-time counters delay each rising drive edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hcnt_q <= '0;
            lcnt_q <= '0;
        end
        else if (clk_en)
        begin
            if (ph_sync_q[1] && !ph_prev_q)
                hcnt_q <= dead_q;
            else if (hcnt_q != '0)
                hcnt_q <= hcnt_q - DEAD_W'(1);
            if (pl_sync_q[1] && !pl_prev_q)
                lcnt_q <= dead_q;
            else if (lcnt_q != '0)
                lcnt_q <= lcnt_q - DEAD_W'(1);
        end
    end

    always_comb
    begin
        high_side_gate_drive_d = ph_sync_q[1] && (periph_q[ABE_PE_HDLY_BYP] ||
            (ph_prev_q ? hcnt_q <= DEAD_W'(1) : dead_q == '0));
        low_side_gate_drive_d = pl_sync_q[1] && (periph_q[ABE_PE_LDLY_BYP] ||
            (pl_prev_q ? lcnt_q <= DEAD_W'(1) : dead_q == '0));
        if (kill)
        begin
            high_side_gate_drive_d = 1'b0;
            low_side_gate_drive_d = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            high_side_gate_drive_q <= 1'b0;
            low_side_gate_drive_q <= 1'b0;
        end
        else if (clk_en)
        begin
            high_side_gate_drive_q <= high_side_gate_drive_d;
            low_side_gate_drive_q <= low_side_gate_drive_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enables, start pulse and gate drives straight from flops
    assign neg_sense_pulldown_en = periph_q[ABE_PE_PULLDOWN];
    assign pos_sense_pullup_en = periph_q[ABE_PE_PULLUP];
    assign overvoltage_detect_en = analog_q[ABE_AE_OV_DET];
    assign undervoltage_detect_en = analog_q[ABE_AE_UV_DET];
    assign efficiency_meas_start = meas_start_q;
    assign slope_comp_bypass = analog_q[ABE_AE_SLOPE_BYP];
    assign current_meas_en = analog_q[ABE_AE_CUR_MEAS];
    assign temp_sensor_en = analog_q[ABE_AE_TEMP_SENS];
    assign efficiency_circuit_en = analog_q[ABE_AE_EFF_CIRC];
    assign voltage_path_en = analog_q[ABE_AE_VPATH];
    assign high_side_gate_drive = high_side_gate_drive_q;
    assign low_side_gate_drive = low_side_gate_drive_q;
endmodule : abe_enable_regs
`default_nettype wire

//--- hw/abe_pkg.sv
package abe_pkg;
    // Register byte addresses on the AXI4-Lite bus
    localparam logic [3:0] ABE_PERIPH_EN_ADDR = 4'h0;
    localparam logic [3:0] ABE_ANALOG_EN_ADDR = 4'h4;
    localparam logic [3:0] ABE_DEAD_TIME_ADDR = 4'h8;
    localparam logic [3:0] ABE_STATUS_ADDR = 4'hc;
    localparam int ABE_ADDR_W = 4;
    localparam int ABE_REG_W = 8;
    localparam int ABE_DEAD_W = 8;
    // Peripheral enable register fields
    localparam int ABE_PE_HDLY_BYP = 5;
    localparam int ABE_PE_LDLY_BYP = 4;
    localparam int ABE_PE_PULLDOWN = 3;
    localparam int ABE_PE_PULLUP = 2;
    localparam int ABE_PE_UV_ACCEL = 1;
    localparam int ABE_PE_OV_ACCEL = 0;
    // Analog block enable register fields
    localparam int ABE_AE_OV_DET = 7;
    localparam int ABE_AE_UV_DET = 6;
    localparam int ABE_AE_MEAS_START = 5;
    localparam int ABE_AE_SLOPE_BYP = 4;
    localparam int ABE_AE_CUR_MEAS = 3;
    localparam int ABE_AE_TEMP_SENS = 2;
    localparam int ABE_AE_EFF_CIRC = 1;
    localparam int ABE_AE_VPATH = 0;
    // Status register fields
    localparam int ABE_ST_OV = 0;
    localparam int ABE_ST_UV = 1;
    localparam int ABE_ST_HIGH_SIDE_GATE_DRIVE = 2;
    localparam int ABE_ST_LOW_SIDE_GATE_DRIVE = 3;
    // Reset values and response codes
    localparam logic [7:0] ABE_PE_RESET = 8'h00;
    localparam logic [7:0] ABE_AE_RESET = 8'h00;
    localparam logic [7:0] ABE_DEAD_RESET = 8'h00;
    localparam logic [1:0] ABE_RESP_OKAY = 2'b00;
    localparam logic [1:0] ABE_RESP_SLVERR = 2'b10;
endpackage : abe_pkg

//--- verif/abe_chk.sv
`timescale 1ns/1ps
`default_nettype none
module abe_chk
    import abe_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Register bus
    input wire logic [abe_pkg::ABE_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive path
    input wire logic pwm_high,
    input wire logic pwm_low,
    input wire logic efficiency_meas_start,
    input wire logic high_side_gate_drive,
    input wire logic low_side_gate_drive
);
    // A frozen clock enable stalls everything, so nothing is judged then
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !clk_en);
    ////////////////////////////////////////////////////////////////
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before accepted");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before accepted");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready longer than one cycle");
    meas_pulse_a: assert property (efficiency_meas_start |=> !efficiency_meas_start)
        else $error("measurement start not a single pulse");
    meas_start_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == ABE_ANALOG_EN_ADDR && s_axi_wstrb[0]
        && s_axi_wdata[ABE_AE_MEAS_START] |-> ##[1:4] efficiency_meas_start)
        else $error("measurement start missing");
    high_idle_a: assert property (!pwm_high [*4] |-> !high_side_gate_drive)
        else $error("high drive on without request");
    low_idle_a: assert property (!pwm_low [*4] |-> !low_side_gate_drive)
        else $error("low drive on without request");
    cover property (efficiency_meas_start);
    cover property ($rose(high_side_gate_drive));
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : abe_chk
bind abe_enable_regs abe_chk u_chk (.*);
`default_nettype wire

//--- verif/analog_block_enable_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module analog_block_enable_regs_test;
    import abe_pkg::*;
    logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ov_fault_pin, uv_fault_pin, pwm_high, pwm_low, high_side_gate_drive, low_side_gate_drive;
    logic neg_sense_pulldown_en, pos_sense_pullup_en, overvoltage_detect_en, undervoltage_detect_en;
    logic efficiency_meas_start, slope_comp_bypass, current_meas_en, temp_sensor_en;
    logic efficiency_circuit_en, voltage_path_en;
    logic [7:0] p, a;
    int n_fail = 0;
    int n_compared = 0;
    int k, l1, l2, l3, l4;
    abe_enable_regs dut (.*);
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [6:0] ae_pins(input logic [7:0] v);
        return {v[7:6], v[4:0]};
    endfunction : ae_pins
    task automatic finish_test;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 60)
        begin
            n_fail++;
            $display("Error at %0t: wait ran out, got %h expected %h", $time, n, 60);
            finish_test();
        end
    endtask : tmo
    // Each bus task ends one edge after release so no signal is driven twice in a step
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        int n;
        logic ta, td;
        ta = 1'b0;
        td = 1'b0;
        n = 0;
        s_axi_awaddr <= ad;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) ta = 1'b1;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) td = 1'b1;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(ta && td) && n < 60);
        tmo(n);
        n = 0;
        while (!s_axi_bvalid && n < 60)
        begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
        chk(s_axi_bresp, (ad == ABE_PERIPH_EN_ADDR || ad == ABE_ANALOG_EN_ADDR
            || ad == ABE_DEAD_TIME_ADDR) ? ABE_RESP_OKAY : ABE_RESP_SLVERR);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rbk(input logic [3:0] ad, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 60);
        tmo(n);
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rbk
    task automatic lat(input bit lo, output int n);
        n = 0;
        pwm_high <= !lo;
        pwm_low <= lo;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!(lo ? low_side_gate_drive : high_side_gate_drive) && n < 60);
        tmo(n);
        pwm_high <= 1'b0;
        pwm_low <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask : lat
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {ov_fault_pin, uv_fault_pin, pwm_high, pwm_low, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        clk_en = 1'b1;
        void'($urandom(68));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rbk(ABE_PERIPH_EN_ADDR, 32'h0, ABE_RESP_OKAY);
        rbk(ABE_ANALOG_EN_ADDR, 32'h0, ABE_RESP_OKAY);
        $display("Test reset done");
        for (k = 0; k < 10; k++)
        begin
            p = (k == 0) ? 8'h3f : (k == 1) ? 8'h00 : 8'($urandom()) & 8'h3f;
            a = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom());
            wr(ABE_PERIPH_EN_ADDR, p);
            wr(ABE_ANALOG_EN_ADDR, a);
            rbk(ABE_PERIPH_EN_ADDR, {24'h0, p}, ABE_RESP_OKAY);
            rbk(ABE_ANALOG_EN_ADDR, {24'h0, a}, ABE_RESP_OKAY);
            chk({neg_sense_pulldown_en, pos_sense_pullup_en}, p[3:2]);
            chk({overvoltage_detect_en, undervoltage_detect_en, slope_comp_bypass, current_meas_en,
                temp_sensor_en, efficiency_circuit_en, voltage_path_en}, ae_pins(a));
        end
        rbk(4'h2, 32'h0, ABE_RESP_SLVERR);
        // Lane 0 strobe low and unmapped writes must leave both registers alone
        s_axi_wstrb <= 4'he;
        wr(ABE_PERIPH_EN_ADDR, ~p);
        s_axi_wstrb <= 4'hf;
        wr(4'h2, 8'hff);
        rbk(ABE_PERIPH_EN_ADDR, {24'h0, p}, ABE_RESP_OKAY);
        rbk(ABE_ANALOG_EN_ADDR, {24'h0, a}, ABE_RESP_OKAY);
        $display("Test registers done");
        wr(ABE_DEAD_TIME_ADDR, 8'h05);
        wr(ABE_PERIPH_EN_ADDR, 8'h30);
        lat(1'b0, l1);
        lat(1'b1, l2);
        wr(ABE_PERIPH_EN_ADDR, 8'h00);
        lat(1'b0, l3);
        lat(1'b1, l4);
        chk(l3 - l1, 32'h5);
        chk(l4 - l2, 32'h5);
        // Enable low freezes the synchronisers, so no drive may appear
        clk_en <= 1'b0;
        pwm_high <= 1'b1;
        repeat (10) @(posedge aclk);
        chk(high_side_gate_drive, 1'b0);
        {clk_en, pwm_high} <= 2'b10;
        repeat (8) @(posedge aclk);
        $display("Test dead time done");
        // Forced cases run last, and each releases its fault pin, so a trip cannot spoil later cases
        for (k = 0; k < 8; k++)
        begin
            wr(ABE_PERIPH_EN_ADDR, 8'h30 | {6'h0, k[1], k[1]});
            wr(ABE_ANALOG_EN_ADDR, {k[2], k[2], 6'h0});
            {pwm_high, pwm_low} <= 2'b11;
            repeat (8) @(posedge aclk);
            ov_fault_pin <= !k[0];
            uv_fault_pin <= k[0];
            repeat (6) @(posedge aclk);
            chk(high_side_gate_drive, !(k[1] && k[2]));
            chk(low_side_gate_drive, !(k[1] && k[2]));
            rbk(ABE_STATUS_ADDR, {28'h0, {2{!(k[1] && k[2])}}, k[0] && k[2], !k[0] && k[2]},
                ABE_RESP_OKAY);
            {ov_fault_pin, uv_fault_pin, pwm_high, pwm_low} <= 4'h0;
            repeat (8) @(posedge aclk);
        end
        $display("Test faults done");
        finish_test();
    end
endmodule : analog_block_enable_regs_test
`default_nettype wire
